// File: core/supervisor_pkg.sv
// Package with the timing constants, state type and helpers of the supply supervisor.
package supervisor_pkg;

	localparam longint unsigned CLK_FREQ_HZ = 64'h0000_0000_0BEB_C200;

	// Reset hold times, typical figures in milliseconds, option codes 0 to 5.
	localparam int HOLD_OPTIONS = 6;
	localparam real HOLD_TIME_MS_0 = 1.65;
	localparam real HOLD_TIME_MS_1 = 13.2;
	localparam real HOLD_TIME_MS_2 = 210.0;
	localparam real HOLD_TIME_MS_3 = 420.0;
	localparam real HOLD_TIME_MS_4 = 840.0;
	localparam real HOLD_TIME_MS_5 = 1680.0;
	localparam int HOLD_SEL_RESET = 2;

	// Watchdog windows, typical figures in seconds.
	localparam real LONG_WIN_TIME_S = 54.0;
	localparam real SHORT_WIN_TIME_S = 1.68;

	localparam longint unsigned LONG_WIN_CYCLES_DEF = longint'(LONG_WIN_TIME_S * real'(CLK_FREQ_HZ));
	localparam longint unsigned SHORT_WIN_CYCLES_DEF = longint'(SHORT_WIN_TIME_S * real'(CLK_FREQ_HZ));
	localparam longint unsigned HOLD_MAX_CYCLES = longint'(HOLD_TIME_MS_5 * 1.0e-3 * real'(CLK_FREQ_HZ));

	localparam int HOLD_CNT_W = $clog2(HOLD_MAX_CYCLES + 64'h1);
	localparam int WIN_CNT_W = $clog2(LONG_WIN_CYCLES_DEF + 64'h1);

	// Synchroniser lane assignment.
	localparam int SYNC_W = 5;
	localparam int LANE_PRI_UV = 0;
	localparam int LANE_SEC_UV = 1;
	localparam int LANE_AUX_UV = 2;
	localparam int LANE_MAN_RST_N = 3;
	localparam int LANE_KICK = 4;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h08;

	typedef enum logic [1:0] {
		WD_HOLD,
		WD_LONG,
		WD_SHORT
	} wd_state_type;

	function automatic longint unsigned hold_cycles(input int sel);
		real ms;
		case (sel)
			0: ms = HOLD_TIME_MS_0;
			1: ms = HOLD_TIME_MS_1;
			2: ms = HOLD_TIME_MS_2;
			3: ms = HOLD_TIME_MS_3;
			4: ms = HOLD_TIME_MS_4;
			default: ms = HOLD_TIME_MS_5;
		endcase
		return longint'(ms * 1.0e-3 * real'(CLK_FREQ_HZ));
	endfunction

endpackage

// File: core/input_sync.sv
// Three-stage input synchroniser with agreement filter and change pulse.
`timescale 1ns/10ps
module input_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Asynchronous inputs.
	input wire logic [WIDTH-1:0] async_i,
	// Filtered level and one-cycle change pulse.
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] change_o
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] level_ff;
	logic [WIDTH-1:0] change_ff;
	logic [WIDTH-1:0] nxt_level;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_ff <= INIT;
			stage2_ff <= INIT;
			stage3_ff <= INIT;
		end else begin
			meta_ff <= async_i;
			stage2_ff <= meta_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// A lane only moves once the second and third stages agree, so a single
	// resolved metastable sample cannot produce a false edge.
	always_comb begin
		nxt_level = (stage2_ff & stage3_ff) | (level_ff & (stage2_ff | stage3_ff));
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_ff <= INIT;
			change_ff <= '0;
		end else begin
			level_ff <= nxt_level;
			change_ff <= nxt_level ^ level_ff;
		end
	end

	assign level_o = level_ff;
	assign change_o = change_ff;

endmodule

// File: core/supply_supervisor_watchdog.sv
// Supply supervisor core: reset generation with hold timer and dual-window watchdog.
`timescale 1ns/10ps
module supply_supervisor_watchdog
	import supervisor_pkg::*;
#(
	parameter bit OPEN_DRAIN = 1'b0,
	parameter int HOLD_SEL = HOLD_SEL_RESET,
	parameter longint unsigned HOLD_CYCLES = hold_cycles(HOLD_SEL),
	parameter longint unsigned LONG_WIN_CYCLES = LONG_WIN_CYCLES_DEF,
	parameter longint unsigned SHORT_WIN_CYCLES = SHORT_WIN_CYCLES_DEF
) (
	// Clock and power-on reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Monitor flags, high while the supply is below threshold.
	input wire logic primary_uv_i,
	input wire logic secondary_uv_i,
	input wire logic aux_undervoltage_in_i,
	// Manual reset, active low.
	input wire logic manual_reset_n_i,
	// Watchdog kick from the host.
	input wire logic watchdog_kick_in_i,
	// Reset output pin.
	output logic reset_out_n_o,
	output logic reset_out_oe_o,
	// Watchdog fault output pin.
	output logic watchdog_fault_n_o,
	output logic watchdog_fault_oe_o
);

	localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYCLES - 64'h1);
	localparam logic [WIN_CNT_W-1:0] LONG_LAST = WIN_CNT_W'(LONG_WIN_CYCLES - 64'h1);
	localparam logic [WIN_CNT_W-1:0] SHORT_LAST = WIN_CNT_W'(SHORT_WIN_CYCLES - 64'h1);
	// Pin reset values: reset asserted, fault released.
	localparam logic RST_OUT_INIT = 1'b0;
	localparam logic RST_OE_INIT = 1'b1;
	localparam logic WDO_OUT_INIT = !OPEN_DRAIN;
	localparam logic WDO_OE_INIT = !OPEN_DRAIN;

	logic [SYNC_W-1:0] sync_level;
	logic [SYNC_W-1:0] sync_change;
	logic uv_any;
	logic mr_low;
	logic kick_edge;
	logic rst_cond;

	logic rst_active_ff;
	logic [HOLD_CNT_W-1:0] hold_cnt_ff;
	logic nxt_rst_active;

	wd_state_type wd_state_ff;
	logic [WIN_CNT_W-1:0] wd_cnt_ff;
	logic wd_fault_ff;
	logic wd_expire;
	logic nxt_fault_low;

	logic reset_out_n_ff;
	logic reset_out_oe_ff;
	logic wdo_out_ff;
	logic wdo_oe_ff;

	input_sync #(
		.WIDTH(SYNC_W),
		.INIT(SYNC_RESET)
	) u_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.async_i({watchdog_kick_in_i, manual_reset_n_i, aux_undervoltage_in_i, secondary_uv_i, primary_uv_i}),
		.level_o(sync_level),
		.change_o(sync_change)
	);

	always_comb begin
		uv_any = sync_level[LANE_PRI_UV] | sync_level[LANE_SEC_UV] | sync_level[LANE_AUX_UV];
		mr_low = !sync_level[LANE_MAN_RST_N];
		kick_edge = sync_change[LANE_KICK];
		rst_cond = uv_any | mr_low;
	end

	// Reset hold: any live condition pins the timer at zero, so a new dip
	// during the hold restarts the full hold time.
	always_comb begin
		if (rst_cond) begin
			nxt_rst_active = 1'b1;
		end else if (rst_active_ff && hold_cnt_ff == HOLD_LAST) begin
			nxt_rst_active = 1'b0;
		end else begin
			nxt_rst_active = rst_active_ff;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_active_ff <= 1'b1;
		end else begin
			rst_active_ff <= nxt_rst_active;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hold_cnt_ff <= '0;
		end else if (rst_cond || !nxt_rst_active) begin
			hold_cnt_ff <= '0;
		end else if (hold_cnt_ff != HOLD_LAST) begin
			hold_cnt_ff <= hold_cnt_ff + 1'b1;
		end
	end

	// Watchdog has no enable: it times whenever reset is released, kicked or not.
	always_comb begin
		case (wd_state_ff)
			WD_LONG: wd_expire = (wd_cnt_ff == LONG_LAST);
			WD_SHORT: wd_expire = (wd_cnt_ff == SHORT_LAST);
			default: wd_expire = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_state_ff <= WD_HOLD;
		end else if (nxt_rst_active) begin
			wd_state_ff <= WD_HOLD;
		end else begin
			case (wd_state_ff)
				WD_HOLD: wd_state_ff <= WD_LONG;
				WD_LONG: begin
					if (kick_edge || wd_expire) begin
						wd_state_ff <= WD_SHORT;
					end
				end
				WD_SHORT: wd_state_ff <= WD_SHORT;
				default: wd_state_ff <= WD_HOLD;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_cnt_ff <= '0;
		end else if (nxt_rst_active || wd_state_ff == WD_HOLD || kick_edge || wd_expire) begin
			wd_cnt_ff <= '0;
		end else begin
			wd_cnt_ff <= wd_cnt_ff + 1'b1;
		end
	end

	// The latched fault is dropped by manual reset, by reset itself or by a kick, which
	// lets a fault-to-manual-reset loop release its own fault pin.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_fault_ff <= 1'b0;
		end else if (wd_expire && !rst_cond) begin
			wd_fault_ff <= 1'b1;
		end else if (mr_low || rst_active_ff || kick_edge) begin
			wd_fault_ff <= 1'b0;
		end
	end

	always_comb begin
		nxt_fault_low = !mr_low && (uv_any || wd_fault_ff || (wd_expire && !rst_cond));
	end

	// Pin drivers: open-drain only ever pulls low through the enable.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reset_out_n_ff <= RST_OUT_INIT;
			reset_out_oe_ff <= RST_OE_INIT;
		end else begin
			reset_out_n_ff <= OPEN_DRAIN ? 1'b0 : !nxt_rst_active;
			reset_out_oe_ff <= OPEN_DRAIN ? nxt_rst_active : 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdo_out_ff <= WDO_OUT_INIT;
			wdo_oe_ff <= WDO_OE_INIT;
		end else begin
			wdo_out_ff <= OPEN_DRAIN ? 1'b0 : !nxt_fault_low;
			wdo_oe_ff <= OPEN_DRAIN ? nxt_fault_low : 1'b1;
		end
	end

	assign reset_out_n_o = reset_out_n_ff;
	assign reset_out_oe_o = reset_out_oe_ff;
	assign watchdog_fault_n_o = wdo_out_ff;
	assign watchdog_fault_oe_o = wdo_oe_ff;

	// Pin level as seen on the board, pull-up assumed for open-drain.
	logic rst_pin_low;
	logic wdo_pin_low;
	assign rst_pin_low = reset_out_oe_ff && !reset_out_n_ff;
	assign wdo_pin_low = wdo_oe_ff && !wdo_out_ff;

	property p_uv_resets;
		@(posedge clk_i) disable iff (!resetn_i)
		rst_cond |=> rst_pin_low;
	endproperty
	a_uv_resets: assert property (p_uv_resets) else $error("reset pin not low under a reset condition");

	property p_release_after_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		$fell(rst_active_ff) |-> $past(hold_cnt_ff) == HOLD_LAST && !$past(rst_cond);
	endproperty
	a_release_after_hold: assert property (p_release_after_hold) else $error("reset released early");

	property p_hold_bounded;
		@(posedge clk_i) disable iff (!resetn_i)
		hold_cnt_ff <= HOLD_LAST && (rst_active_ff || hold_cnt_ff == '0);
	endproperty
	a_hold_bounded: assert property (p_hold_bounded) else $error("hold counter out of range");

	property p_hold_restart;
		@(posedge clk_i) disable iff (!resetn_i)
		rst_cond |=> hold_cnt_ff == '0 && rst_active_ff;
	endproperty
	a_hold_restart: assert property (p_hold_restart) else $error("hold timer not restarted");

	property p_expire_fault;
		@(posedge clk_i) disable iff (!resetn_i)
		wd_expire && !rst_cond && !nxt_rst_active |=> wdo_pin_low;
	endproperty
	a_expire_fault: assert property (p_expire_fault) else $error("fault not raised on expiry");

	property p_uv_fault;
		@(posedge clk_i) disable iff (!resetn_i)
		uv_any && !mr_low |=> wdo_pin_low;
	endproperty
	a_uv_fault: assert property (p_uv_fault) else $error("fault not held under undervoltage");

	property p_mr_release;
		@(posedge clk_i) disable iff (!resetn_i)
		mr_low |=> !wdo_pin_low ##1 !wd_fault_ff;
	endproperty
	a_mr_release: assert property (p_mr_release) else $error("fault not released by manual reset");

	property p_cnt_clear;
		@(posedge clk_i) disable iff (!resetn_i)
		kick_edge || rst_active_ff |=> wd_cnt_ff == '0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("watchdog counter not cleared");

	property p_long_first;
		@(posedge clk_i) disable iff (!resetn_i)
		$fell(rst_active_ff) |-> wd_state_ff == WD_LONG && wd_cnt_ff == '0;
	endproperty
	a_long_first: assert property (p_long_first) else $error("long window not used after reset");

	property p_short_after_kick;
		@(posedge clk_i) disable iff (!resetn_i)
		kick_edge && wd_state_ff != WD_HOLD && !nxt_rst_active |=> wd_state_ff == WD_SHORT;
	endproperty
	a_short_after_kick: assert property (p_short_after_kick) else $error("short window not entered");

	property p_open_drain;
		@(posedge clk_i) disable iff (!resetn_i)
		(OPEN_DRAIN && !reset_out_n_ff && !wdo_out_ff) || (!OPEN_DRAIN && reset_out_oe_ff && wdo_oe_ff);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain output driven high");

	property p_kick_sync;
		@(posedge clk_i) disable iff (!resetn_i)
		kick_edge |-> sync_level[LANE_KICK] != $past(sync_level[LANE_KICK]);
	endproperty
	a_kick_sync: assert property (p_kick_sync) else $error("kick edge without level change");

	// Counters move one step at a time, so a stuck or skipping timer shows up at once.
	property p_hold_step;
		@(posedge clk_i) disable iff (!resetn_i)
		rst_active_ff && !rst_cond && hold_cnt_ff != HOLD_LAST |=> hold_cnt_ff == $past(hold_cnt_ff) + 1'b1;
	endproperty
	a_hold_step: assert property (p_hold_step) else $error("hold counter did not advance");

	property p_wdo_release;
		@(posedge clk_i) disable iff (!resetn_i)
		!uv_any && !wd_fault_ff && !wd_expire |=> !wdo_pin_low;
	endproperty
	a_wdo_release: assert property (p_wdo_release) else $error("fault pin held without a cause");

	property p_short_bounded;
		@(posedge clk_i) disable iff (!resetn_i)
		wd_state_ff == WD_SHORT |-> wd_cnt_ff <= SHORT_LAST;
	endproperty
	a_short_bounded: assert property (p_short_bounded) else $error("short window overran");

	property p_keeps_timing;
		@(posedge clk_i) disable iff (!resetn_i)
		wd_state_ff != WD_HOLD && !nxt_rst_active && !kick_edge && !wd_expire |=> wd_cnt_ff == $past(wd_cnt_ff) + 1'b1;
	endproperty
	a_keeps_timing: assert property (p_keeps_timing) else $error("watchdog counter stalled");

	property p_long_restart;
		@(posedge clk_i) disable iff (!resetn_i)
		wd_state_ff == WD_HOLD && !nxt_rst_active |=> wd_state_ff == WD_LONG && wd_cnt_ff == '0;
	endproperty
	a_long_restart: assert property (p_long_restart) else $error("long window not restarted");

	c_hold_release: cover property (@(posedge clk_i) disable iff (!resetn_i) $fell(rst_active_ff));
	c_kick_short: cover property (@(posedge clk_i) disable iff (!resetn_i) kick_edge && wd_state_ff == WD_LONG);
	c_fault: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(wd_fault_ff));
	c_mr_clear: cover property (@(posedge clk_i) disable iff (!resetn_i) wd_fault_ff && mr_low);
	c_long_expire: cover property (@(posedge clk_i) disable iff (!resetn_i) wd_expire && wd_state_ff == WD_LONG);

endmodule

// File: verif/host_kick_model.sv
// Host processor model that toggles the watchdog kick line at a chosen spacing.
`timescale 1ns/10ps
module host_kick_model (
	// Clock.
	input wire logic clk_i,
	// Control from the bench.
	input wire logic enable_i,
	input wire logic [7:0] interval_i,
	// Kick line towards the supervisor.
	output logic kick_o
);
	int cnt_ff;

	initial begin
		kick_o = 1'b0;
		cnt_ff = 0;
	end

	// The line only moves at a clock edge, so a slow host is a large interval, a prompt one a small one.
	always @(posedge clk_i) begin
		if (!enable_i) begin
			cnt_ff <= 0;
		end else if (cnt_ff >= int'(interval_i)) begin
			cnt_ff <= 0;
			kick_o <= ~kick_o;
		end else begin
			cnt_ff <= cnt_ff + 1;
		end
	end
endmodule

// File: verif/supply_supervisor_watchdog_test.sv
// Self-checking bench for the supply supervisor with a cycle model of reset and watchdog.
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin num_checks++; if ((exp) !== (got)) begin n_errors++; \
	$display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module supply_supervisor_watchdog_test;
	import supervisor_pkg::*;
	localparam int HOLD = 20;
	localparam int LONG = 200;
	localparam int SHORT = 50;
	localparam int TIMEOUT_CYC = 20000;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic primary_uv_i = 1'b0;
	logic secondary_uv_i = 1'b0;
	logic aux_undervoltage_in_i = 1'b0;
	logic manual_reset_n_i = 1'b1;
	logic kick_en = 1'b0;
	logic [7:0] kick_gap = 8'h14;
	logic kick;
	logic reset_out_n_o, reset_out_oe_o, watchdog_fault_n_o, watchdog_fault_oe_o;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int m_hold = 0;
	int m_win = 0;
	bit m_rst = 1'b1;
	bit m_long = 1'b1;
	bit m_latch = 1'b0;
	logic m_kick_prev = 1'b0;
	logic [31:0] seed = 32'h0001_6347;

	always #2.5 clk_i = ~clk_i;

	supply_supervisor_watchdog #(.OPEN_DRAIN(1'b0), .HOLD_CYCLES(HOLD), .LONG_WIN_CYCLES(LONG),
		.SHORT_WIN_CYCLES(SHORT)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .primary_uv_i(primary_uv_i),
		.secondary_uv_i(secondary_uv_i), .aux_undervoltage_in_i(aux_undervoltage_in_i),
		.manual_reset_n_i(manual_reset_n_i), .watchdog_kick_in_i(kick), .reset_out_n_o(reset_out_n_o),
		.reset_out_oe_o(reset_out_oe_o), .watchdog_fault_n_o(watchdog_fault_n_o),
		.watchdog_fault_oe_o(watchdog_fault_oe_o));

	host_kick_model u_host (.clk_i(clk_i), .enable_i(kick_en), .interval_i(kick_gap), .kick_o(kick));

	// Cycle model without synchroniser latency; checks are placed well clear of its transitions.
	always @(posedge clk_i) begin
		if (!resetn_i || primary_uv_i || secondary_uv_i || aux_undervoltage_in_i || !manual_reset_n_i) begin
			m_rst = 1'b1;
			m_hold = 0;
			m_win = 0;
			m_long = 1'b1;
			m_latch = 1'b0;
		end else if (m_rst) begin
			m_hold++;
			if (m_hold >= HOLD) m_rst = 1'b0;
		end else if (kick !== m_kick_prev) begin
			m_win = 0;
			m_long = 1'b0;
			m_latch = 1'b0;
		end else begin
			m_win++;
			if (m_win >= (m_long ? LONG : SHORT)) begin
				m_latch = 1'b1;
				m_long = 1'b0;
				m_win = 0;
			end
		end
		m_kick_prev = kick;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == TIMEOUT_CYC) begin
			n_errors++;
			end_of_test();
		end
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic set_uv(input int sel, input logic v);
		case (sel)
			0: primary_uv_i = v;
			1: secondary_uv_i = v;
			default: aux_undervoltage_in_i = v;
		endcase
	endtask

	// Push-pull build: both enables stay high and the data bits carry the level.
	task automatic check_pins();
		logic exp_fault_n;
		exp_fault_n = !((primary_uv_i || secondary_uv_i || aux_undervoltage_in_i || m_latch) && manual_reset_n_i);
		`CHECK("reset_out_n", !m_rst, reset_out_n_o)
		`CHECK("watchdog_fault_n", exp_fault_n, watchdog_fault_n_o)
		`CHECK("reset_out_oe", 1'b1, reset_out_oe_o)
		`CHECK("watchdog_fault_oe", 1'b1, watchdog_fault_oe_o)
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		int sel;
		int off;
		step(4);
		check_pins();
		step(4);
		resetn_i = 1'b1;
		step(10);
		check_pins();
		step(HOLD + 5);
		check_pins();
		// No kick at all: the long window must run out and raise the fault.
		step(LONG - 30);
		check_pins();
		step(30);
		check_pins();
		seed = lfsr_next(seed);
		kick_gap = 8'(10 + seed % 21);
		kick_en = 1'b1;
		step(40);
		check_pins();
		step(3 * SHORT);
		check_pins();
		kick_en = 1'b0;
		step(SHORT + 10);
		check_pins();
		// Each monitor flag in turn, with a second dip during the hold to restart it.
		seed = lfsr_next(seed);
		off = int'(seed[1:0]);
		for (int i = 0; i < 3; i++) begin
			sel = (i + off) % 3;
			set_uv(sel, 1'b1);
			step(10);
			check_pins();
			set_uv(sel, 1'b0);
			step(8);
			check_pins();
			set_uv(sel, 1'b1);
			step(4);
			set_uv(sel, 1'b0);
			step(14);
			check_pins();
			step(HOLD);
			check_pins();
		end
		// Manual reset while an undervoltage fault shows releases the fault pin.
		set_uv(0, 1'b1);
		step(10);
		check_pins();
		manual_reset_n_i = 1'b0;
		step(10);
		check_pins();
		set_uv(0, 1'b0);
		step(30);
		check_pins();
		manual_reset_n_i = 1'b1;
		step(10);
		check_pins();
		step(HOLD + 5);
		check_pins();
		step(SHORT + 20);
		check_pins();
		step(LONG);
		check_pins();
		// Manual reset pulsed by the bench while the watchdog fault shows, then a single kick inside the long window.
		manual_reset_n_i = 1'b0;
		step(10);
		check_pins();
		manual_reset_n_i = 1'b1;
		step(HOLD + 15);
		check_pins();
		kick_en = 1'b1;
		step(int'(kick_gap) + 1);
		kick_en = 1'b0;
		step(SHORT + 10);
		check_pins();
		end_of_test();
	end
endmodule
